// File: rtl/input_pga_control_regs.sv
// Purpose: right gain register and left input configuration register
// Assumes: single clock, synchronous active-low reset, clock enable freezes state
// Notes:   read data valid the cycle after the read strobe
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "input_pga_map.svh"
module input_pga_control_regs
  import input_pga_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire in_mode_t    rightMode,
  output logic [15:0]      regRdData,
  output right_gain_t      rightGain,
  output left_path_t       leftPath
);
  // ==========================================================
  // registers
  logic       rightSilence_ff;
  logic [4:0] rightCode_ff;
  logic       leftCmr_ff;
  logic [1:0] leftNSel_ff;
  logic [1:0] leftPSel_ff;
  logic [1:0] leftMode_ff;
  logic [15:0] nxt_rdData;
  logic signed [9:0] gainDec;
  logic       gainRes;
  in_mode_t   leftMode;

  function automatic pin_t pinOf(input logic [1:0] s);
    if (s[1]) return PIN_THIRD;
    return s[0] ? PIN_SECOND : PIN_FIRST;
  endfunction : pinOf

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rightSilence_ff <= `RST_RIGHT_MUTE;
      rightCode_ff    <= `RST_RIGHT_CODE;
    end else if (clkEn && regWr && regAddr == `OFF_RIGHT_INPUT_GAIN) begin
      rightSilence_ff <= regWrData[`BIT_RIGHT_MUTE];
      rightCode_ff    <= regWrData[4:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      leftCmr_ff  <= `RST_LEFT_CMR;
      leftNSel_ff <= `RST_LEFT_NSEL;
      leftPSel_ff <= `RST_LEFT_PSEL;
      leftMode_ff <= `RST_LEFT_MODE;
    end else if (clkEn && regWr && regAddr == `OFF_LEFT_INPUT_CONFIG) begin
      leftCmr_ff  <= regWrData[`BIT_LEFT_CMR];
      leftNSel_ff <= regWrData[5:4];
      leftPSel_ff <= regWrData[3:2];
      leftMode_ff <= regWrData[1:0];
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    nxt_rdData = 16'h0000;
    case (regAddr)
      `OFF_RIGHT_INPUT_GAIN:  nxt_rdData = {8'h00, rightSilence_ff, 2'h0, rightCode_ff};
      `OFF_LEFT_INPUT_CONFIG: nxt_rdData = {9'h000, leftCmr_ff, leftNSel_ff, leftPSel_ff,
                                            leftMode_ff};
      default:                nxt_rdData = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      regRdData <= 16'h0000;
    end else if (clkEn) begin
      regRdData <= regRd ? nxt_rdData : 16'h0000;
    end
  end

  // ==========================================================
  // decoded controls
  pga_gain_decode i_pga_gain_decode (
    .code        (rightCode_ff),
    .mode        (rightMode),
    .gainTenthDb (gainDec),
    .reserved    (gainRes)
  );

  assign leftMode = in_mode_t'(leftMode_ff);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rightGain <= '{silence: 1'b1, code: 5'h05, gainTenthDb: 10'sh000, reserved: 1'b0};
      leftPath  <= '{cmrActive: 1'b0, invPin: PIN_FIRST, nonInvPin: PIN_SECOND,
                     mode: MODE_SINGLE};
    end else if (clkEn) begin
      rightGain.silence     <= rightSilence_ff;
      rightGain.code        <= rightCode_ff;
      rightGain.gainTenthDb <= gainDec;
      rightGain.reserved    <= gainRes;
      leftPath.cmrActive    <= leftCmr_ff && leftMode == MODE_DIFF_LINE;
      leftPath.mode         <= leftMode;
      if (leftMode == MODE_DIFF_MIC) begin
        leftPath.invPin    <= pinOf(leftPSel_ff);
        leftPath.nonInvPin <= pinOf(leftNSel_ff);
      end else begin
        leftPath.invPin    <= pinOf(leftNSel_ff);
        leftPath.nonInvPin <= pinOf(leftPSel_ff);
      end
    end
  end
endmodule : input_pga_control_regs
`default_nettype wire

// File: rtl/input_pga_map.svh
// Purpose: offsets, field positions, reset values for the input gain-stage control registers
// Assumes: plain register port, 8-bit address, 16-bit data
// Notes:   right configuration field arrives as an input (its register lies elsewhere)
//
// Summary of operation
// - right stage muted while bit 7 of right gain register is 1; resets to 1.
// - single-ended or line: 5-bit code maps monotonic -1.5 dB to +28.3 dB.
// - mic: 00001 is +12 dB, 3 dB steps, 00111 and up give +30 dB.
// - right gain code resets to 00101 (0 dB line, +24 dB mic).
// - left bit 6 enables common-mode rejection, resets 1, only in differential line.
// - bits 5:4 reset 00, choose inverting pin; non-inverting side in mic mode.
// - bits 3:2 reset 01, choose non-inverting pin; inverting side in mic mode.
// - pin code 00 first pin, 01 second pin, 1X third pin.
// - left configuration bits 1:0 reset 00: 00 single, 01 line, 10 mic, 11 reserved.
// - right configuration uses the same four-code encoding.
`ifndef INPUT_PGA_MAP_SVH
`define INPUT_PGA_MAP_SVH
// ==========================================================
// offsets and fields
`define OFF_RIGHT_INPUT_GAIN  8'h2d
`define OFF_LEFT_INPUT_CONFIG 8'h2e
`define BIT_RIGHT_MUTE        7
`define BIT_LEFT_CMR          6
`define RST_RIGHT_MUTE        1'h1
`define RST_RIGHT_CODE        5'h05
`define RST_LEFT_CMR          1'h1
`define RST_LEFT_NSEL         2'h0
`define RST_LEFT_PSEL         2'h1
`define RST_LEFT_MODE         2'h0
`endif

// File: rtl/input_pga_pkg.sv
// Purpose: types for the input gain-stage control registers
// Assumes: nothing
// Notes:   gain expressed in tenths of a dB, signed
package input_pga_pkg;
  typedef enum logic [1:0] {MODE_SINGLE, MODE_DIFF_LINE, MODE_DIFF_MIC, MODE_RESERVED} in_mode_t;
  typedef enum logic [1:0] {PIN_FIRST, PIN_SECOND, PIN_THIRD, PIN_NONE} pin_t;
  typedef struct packed {
    logic              silence;
    logic [4:0]        code;
    logic signed [9:0] gainTenthDb;
    logic              reserved;
  } right_gain_t;
  typedef struct packed {
    logic cmrActive;
    pin_t invPin;
    pin_t nonInvPin;
    in_mode_t mode;
  } left_path_t;
endpackage : input_pga_pkg

// File: rtl/pga_gain_decode.sv
// Purpose: gain code to tenths of a dB
// Assumes: mode from configuration field
// Notes:   combinational
`timescale 1ns/1ns
`default_nettype none
module pga_gain_decode
  import input_pga_pkg::*;
(
  input  wire logic [4:0]        code,
  input  wire in_mode_t          mode,
  output logic signed [9:0]      gainTenthDb,
  output logic                   reserved
);
  // ==========================================================
  // line table
  function automatic logic signed [9:0] lineGain(input logic [4:0] c);
    logic signed [9:0] t [32];
    t = '{-15, -13, -10, -7, -3, 0, 3, 7, 10, 14, 18, 23, 27, 32, 37, 42,
          48, 54, 60, 67, 75, 83, 92, 102, 114, 127, 143, 162, 192, 223, 252, 283};
    return t[c];
  endfunction : lineGain

  always_comb begin
    reserved    = 1'b0;
    gainTenthDb = 10'sh000;
    case (mode)
      MODE_SINGLE, MODE_DIFF_LINE: gainTenthDb = lineGain(code);
      MODE_DIFF_MIC: begin
        if (code == 5'h00) begin
          reserved = 1'b1;
        end else if (code >= 5'h07) begin
          gainTenthDb = 10'sd300;
        end else begin
          gainTenthDb = 10'(90 + 30 * int'(code));
        end
      end
      default: reserved = 1'b1;
    endcase
  end
endmodule : pga_gain_decode
`default_nettype wire

// File: verif/input_pga_control_regs_asserts.sv
// Purpose: port checks, gain stage registers
// Assumes: clkEn high near writes
// Notes:   bound by the bench
`timescale 1ns/1ns
`default_nettype none
// ==========
// checker
module pga_regs_chk
  import input_pga_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        clkEn,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire in_mode_t    rightMode,
  input wire logic [15:0] regRdData,
  input wire right_gain_t rightGain,
  input wire left_path_t  leftPath
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // line-family gain table in tenths of a dB, one entry per code
  function automatic int lineRef(input logic [4:0] c);
    int t [32] = '{-15, -13, -10, -7, -3, 0, 3, 7, 10, 14, 18, 23, 27, 32, 37, 42,
                   48, 54, 60, 67, 75, 83, 92, 102, 114, 127, 143, 162, 192, 223, 252, 283};
    return t[c];
  endfunction : lineRef
  property p_mute; clkEn && regWr && regAddr == 8'h2d ##1 clkEn
    |=> rightGain.silence == $past(regWrData[7], 2); endproperty
  a_mute: assert property (p_mute) else $error("mute bit");
  property p_line; clkEn && rightMode inside {MODE_SINGLE, MODE_DIFF_LINE} |=>
    rightGain.gainTenthDb == lineRef(rightGain.code); endproperty
  a_line: assert property (p_line) else $error("line gain");
  property p_mic; clkEn && rightMode == MODE_DIFF_MIC |=> (rightGain.code == 5'h00 ?
    rightGain.reserved : rightGain.gainTenthDb ==
    (rightGain.code > 5'h06 ? 300 : 90 + 30 * rightGain.code)); endproperty
  a_mic: assert property (p_mic) else $error("mic gain");
  property p_rdIdle; clkEn && !regRd |=> regRdData == 16'h0000; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("idle read data");
  property p_rdMap; clkEn && regRd && !(regAddr inside {8'h2d, 8'h2e})
    |=> regRdData == 16'h0000; endproperty
  a_rdMap: assert property (p_rdMap) else $error("unmapped read");
  property p_freeze; !clkEn |=> $stable(rightGain) && $stable(leftPath); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");
  property p_cmr; leftPath.cmrActive |-> leftPath.mode == MODE_DIFF_LINE; endproperty
  a_cmr: assert property (p_cmr) else $error("cmr outside line");
  property p_pin; leftPath.invPin != PIN_NONE && leftPath.nonInvPin != PIN_NONE; endproperty
  a_pin: assert property (p_pin) else $error("pin code");
  c_mic: cover property (rightMode == MODE_DIFF_MIC && rightGain.code == 5'h1f);
  c_b2b: cover property (regWr ##1 regRd);
  c_cmr: cover property (leftPath.cmrActive);
endmodule : pga_regs_chk
`default_nettype wire

// File: verif/input_pga_control_regs_tb.sv
// Purpose: bench for input_pga_control_regs
// Assumes: tasks start just after a rising edge
// Notes:   table rows, then reset and freeze
`timescale 1ns/1ns
`default_nettype none
// ==========
// bench
module input_pga_control_regs_tb
  import input_pga_pkg::*;
;
  typedef struct packed {
    logic [7:0] a; logic [15:0] w; in_mode_t m; logic [15:0] r; logic [9:0] o;
  } row_t;
  logic        clk_sys, reset_n, clkEn, regWr, regRd;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData, got;
  in_mode_t    rightMode;
  right_gain_t rightGain;
  left_path_t  leftPath;
  int          n_fail, samples_checked;
  row_t        rows [10] = '{ // no reserved mode or mic code 00000 is ever written
    '{8'h2d, 16'h0000, MODE_SINGLE, 16'h0000, 10'h3f1}, '{8'h2d, 16'hffff, MODE_DIFF_LINE, 16'h009f, 10'h11b},
    '{8'h2d, 16'h0001, MODE_DIFF_MIC, 16'h0001, 10'h078}, '{8'h2d, 16'h0006, MODE_DIFF_MIC, 16'h0006, 10'h10e},
    '{8'h2d, 16'h0007, MODE_DIFF_MIC, 16'h0007, 10'h12c}, '{8'h2d, 16'h001f, MODE_DIFF_MIC, 16'h001f, 10'h12c},
    '{8'h2e, 16'h0079, MODE_SINGLE, 16'h0079, 10'h069}, '{8'h2e, 16'h0026, MODE_SINGLE, 16'h0026, 10'h01a},
    '{8'h2e, 16'h00c4, MODE_SINGLE, 16'h0044, 10'h004}, '{8'h2c, 16'hffff, MODE_SINGLE, 16'h0000, 10'h004}};
  input_pga_control_regs i_input_pga_control_regs (.clk_sys, .reset_n, .clkEn, .regAddr,
    .regWrData, .regWr, .regRd, .rightMode, .regRdData, .rightGain, .leftPath);
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 got = regRdData;
  endtask : rd
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rst;
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask : rst
  task automatic complete_run;
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (1000) @(posedge clk_sys);
    n_fail++;
    complete_run();
  end
  initial begin
    {reset_n, clkEn, regWr, regRd, regAddr, regWrData} = 28'h4000000;
    rightMode = MODE_SINGLE;
    n_fail = 0;
    samples_checked = 0;
    rst();
    foreach (rows[i]) begin
      rightMode <= rows[i].m;
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk(got, rows[i].r);
      repeat (2) @(posedge clk_sys);
      #1 chk({6'h0, rows[i].a == 8'h2d ? rightGain.gainTenthDb : {3'h0, leftPath}}, {6'h0, rows[i].o});
    end
    $display("rows done");
    rst();
    rightMode <= MODE_DIFF_MIC;
    rd(8'h2d);
    chk(got, 16'h0085);
    rd(8'h2e);
    chk(got, 16'h0044);
    chk({6'h0, rightGain.gainTenthDb}, 16'h00f0);
    chk({9'h0, leftPath}, 16'h0004);
    chk({10'h0, rightGain.silence, rightGain.code}, 16'h0025);
    $display("reset done");
    clkEn <= 1'b0;
    wr(8'h2d, 16'h0000);
    clkEn <= 1'b1;
    rd(8'h2d);
    chk(got, 16'h0085);
    chk({10'h0, rightGain.silence, rightGain.code}, 16'h0025);
    $display("freeze done");
    complete_run();
  end
endmodule : input_pga_control_regs_tb
bind input_pga_control_regs pga_regs_chk i_pga_regs_chk (.clk_sys, .reset_n, .clkEn, .regAddr,
  .regWrData, .regWr, .regRd, .rightMode, .regRdData, .rightGain, .leftPath);
`default_nettype wire
